//--- logic/pms_map.svh
// Constant map for the page, mode and stack pointer register block.
// Assumes inclusion by the package and the bench; definitions only.
// Notes on behaviour
// - Sixty-four pages of sixteen registers overlay the top register group.
// - Top group accesses reach the matching register of the selected page.
// - Page select holds the page number 0 to 63 in bits 7 to 2.
// - Page select bits 1 and 0 read zero and ignore writes.
// - Mode control resets to 1110 0000.
// - Mode bit 7 set puts the system stack in the register file.
// - Mode bit 6 likewise places the user stack.
// - Mode bit 5 set halves the oscillator input clock.
// - Mode bits 4 to 2 divide the CPU clock by 1 to 8.
// - Mode bit 1 must be set for an external bus request to be honoured.
// - Mode bit 0 set floats multiplexed bus lines and strobes.
// - Bus float leaves port 1 lines used as general I/O alone.
// - Two independent sixteen-bit stack pointers, system and user.
// - Push pre-decrements then writes; pop reads then post-increments.
// - A word push fills the two locations below the old pointer.
// - A pop leaves the stack locations it reads unchanged.
// - Interrupt entry pushes PC and flags; a call pushes only PC.
// - Internal system stack uses the low byte; external uses both bytes.
// - Internal user stack uses only the low pointer byte.
// - External stack accesses always go to data memory space.
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH
`define PMS_IDX_PAGE 8'hEA
`define PMS_IDX_MODE 8'hEB
`define PMS_IDX_USPH 8'hEC
`define PMS_IDX_USPL 8'hED
`define PMS_IDX_SSPH 8'hEE
`define PMS_IDX_SSPL 8'hEF
`define PMS_IDX_TOP 4'hF
`define PMS_MODE_RST 8'hE0
`define PMS_MODE_SSP 7
`define PMS_MODE_USP 6
`define PMS_MODE_OSC_HALVE_ENABLE 5
`define PMS_MODE_PRS_HI 4
`define PMS_MODE_PRS_LO 2
`define PMS_MODE_BRQ 1
`define PMS_MODE_BUS_FLOAT_ENABLE 0
`define PMS_PAGES 64
`define PMS_PAGE_REGS 16
`endif

//--- logic/pms_pkg.sv
// Types shared by the page, mode and stack pointer register block.
// Assumes the constant map header sits beside it.
package pms_pkg;
   `include "pms_map.svh"
   typedef enum logic [2:0] {
      PMS_OP_PUSH = 3'h0,
      PMS_OP_PUSHW = 3'h1,
      PMS_OP_POP = 3'h2,
      PMS_OP_POPW = 3'h3,
      PMS_OP_IRQ = 3'h4,
      PMS_OP_CALL = 3'h5
   } pms_op_t;
   typedef enum logic [1:0] {
      PMS_IDLE = 2'h0,
      PMS_ACC = 2'h1
   } pms_state_t;
   // One stack command from the core sequencer.
   typedef struct packed {
      logic valid;
      pms_op_t op;
      logic user;
      logic [15:0] data;
      logic [15:0] pc;
      logic [7:0] flags;
   } pms_cmd_t;
   // One byte access to register file or data memory.
   typedef struct packed {
      logic req;
      logic we;
      logic ext;
      logic dspace;
      logic [15:0] addr;
      logic [7:0] wdata;
   } pms_acc_t;
endpackage

//--- logic/pms_regs.sv
// Page select, mode control and stack pointer registers with an APB slave.
// Assumes APB master on i_clk, a core issuing stack commands, and a memory
// or register file that acknowledges each byte access with i_mem_ack.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module pms_regs
   import pms_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire pms_cmd_t i_stk_cmd,
   output logic o_stk_busy,
   output pms_acc_t o_mem,
   input wire logic i_mem_ack,
   input wire logic [7:0] i_mem_rdata,
   output logic [15:0] o_pop_data,
   output logic o_pop_done,
   output logic o_cpu_tick,
   input wire logic i_ext_bus_request_input,
   output logic o_bus_grant_ok,
   input wire logic i_p0_addr_mode,
   input wire logic [7:0] i_p1_addr_mask,
   output logic o_p0_float,
   output logic [7:0] o_p1_float,
   output logic o_ctl_float
);
   // Steps a pointer; an internal stack only moves the low byte.
   function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic internal, input logic up);
      logic [15:0] n;
      n = up ? sp + 16'h0001 : sp - 16'h0001;
      sp_step = internal ? {sp[15:8], n[7:0]} : n;
   endfunction

   logic [5:0] page_r, page_nxt;
   logic [7:0] mode_r, mode_nxt;
   logic [15:0] ssp_r, ssp_nxt, usp_r, usp_nxt;
   logic [7:0] page_mem [0:`PMS_PAGES*`PMS_PAGE_REGS-1];
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   pms_state_t st_r, st_nxt;
   pms_acc_t mem_r, mem_nxt;
   logic [23:0] buf_r, buf_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   logic user_r, user_nxt;
   logic [15:0] pop_r, pop_nxt;
   logic pop_done_r, pop_done_nxt;
   logic busy_r, busy_nxt;
   logic [7:0] idx;
   logic acc, wr_ok, top_hit, mapped;
   logic [9:0] pm_addr;
   logic cur_int;
   logic [15:0] cur_sp, nsp;
   logic half_r, half_nxt, tick_r, tick_nxt;
   logic [2:0] pcnt_r, pcnt_nxt;
   logic brq_r, brq_nxt, p0f_r, p0f_nxt, ctlf_r, ctlf_nxt;
   logic [7:0] p1f_r, p1f_nxt;

   // Bus decode; the word index is the byte address over four.
   assign idx = i_paddr[9:2];
   assign acc = i_psel && i_penable && !pready_r;
   assign top_hit = (idx[7:4] == `PMS_IDX_TOP);
   assign pm_addr = {page_r, idx[3:0]};
   assign mapped = top_hit || (idx == `PMS_IDX_PAGE) || (idx == `PMS_IDX_MODE) ||
      (idx >= `PMS_IDX_USPH && idx <= `PMS_IDX_SSPL);
   // A bus access waits while a stack sequence runs so the pointers never race.
   assign wr_ok = acc && (st_r == PMS_IDLE) && !i_stk_cmd.valid;
   assign cur_int = user_r ? mode_r[`PMS_MODE_USP] : mode_r[`PMS_MODE_SSP];
   assign cur_sp = user_r ? usp_r : ssp_r;

   // APB answer: one access cycle of wait, then pready with data.
   always_comb begin
      pready_nxt = wr_ok;
      pslverr_nxt = wr_ok && (i_paddr[31:10] != 22'h0 || i_paddr[1:0] != 2'h0 || !mapped);
      prdata_nxt = 32'h0;
      if (wr_ok && !i_pwrite) begin
         if (top_hit) begin
            prdata_nxt = {24'h0, page_mem[pm_addr]};
         end else begin
            case (idx)
               `PMS_IDX_PAGE: prdata_nxt = {24'h0, page_r, 2'h0};
               `PMS_IDX_MODE: prdata_nxt = {24'h0, mode_r};
               `PMS_IDX_USPH: prdata_nxt = {24'h0, usp_r[15:8]};
               `PMS_IDX_USPL: prdata_nxt = {24'h0, usp_r[7:0]};
               `PMS_IDX_SSPH: prdata_nxt = {24'h0, ssp_r[15:8]};
               `PMS_IDX_SSPL: prdata_nxt = {24'h0, ssp_r[7:0]};
               default: prdata_nxt = 32'h0;
            endcase
         end
      end
   end

   // Stack sequencer and software register writes.
   always_comb begin
      page_nxt = page_r;
      mode_nxt = mode_r;
      ssp_nxt = ssp_r;
      usp_nxt = usp_r;
      st_nxt = st_r;
      mem_nxt = mem_r;
      buf_nxt = buf_r;
      cnt_nxt = cnt_r;
      user_nxt = user_r;
      pop_nxt = pop_r;
      pop_done_nxt = 1'b0;
      nsp = 16'h0;
      if (wr_ok && i_pwrite && !pslverr_nxt) begin
         case (idx)
            `PMS_IDX_PAGE: page_nxt = i_pwdata[7:2];
            `PMS_IDX_MODE: mode_nxt = i_pwdata[7:0];
            `PMS_IDX_USPH: usp_nxt[15:8] = i_pwdata[7:0];
            `PMS_IDX_USPL: usp_nxt[7:0] = i_pwdata[7:0];
            `PMS_IDX_SSPH: ssp_nxt[15:8] = i_pwdata[7:0];
            `PMS_IDX_SSPL: ssp_nxt[7:0] = i_pwdata[7:0];
            default: page_nxt = page_r;
         endcase
      end
      case (st_r)
         PMS_IDLE: begin
            if (i_stk_cmd.valid) begin
               // Interrupt entry and calls always use the system stack.
               user_nxt = i_stk_cmd.user && !(i_stk_cmd.op inside {PMS_OP_IRQ, PMS_OP_CALL});
               mem_nxt.we = !(i_stk_cmd.op inside {PMS_OP_POP, PMS_OP_POPW});
               mem_nxt.ext = !(user_nxt ? mode_r[`PMS_MODE_USP] : mode_r[`PMS_MODE_SSP]);
               mem_nxt.dspace = mem_nxt.ext;
               mem_nxt.req = 1'b1;
               pop_nxt = 16'h0;
               case (i_stk_cmd.op)
                  PMS_OP_PUSH: begin
                     buf_nxt = {16'h0, i_stk_cmd.data[7:0]};
                     cnt_nxt = 2'h1;
                  end
                  PMS_OP_PUSHW: begin
                     buf_nxt = {8'h0, i_stk_cmd.data};
                     cnt_nxt = 2'h2;
                  end
                  PMS_OP_IRQ: begin
                     buf_nxt = {i_stk_cmd.flags, i_stk_cmd.pc};
                     cnt_nxt = 2'h3;
                  end
                  PMS_OP_CALL: begin
                     buf_nxt = {8'h0, i_stk_cmd.pc};
                     cnt_nxt = 2'h2;
                  end
                  PMS_OP_POPW: cnt_nxt = 2'h2;
                  default: cnt_nxt = 2'h1;
               endcase
               nsp = user_nxt ? usp_r : ssp_r;
               if (mem_nxt.we) begin
                  nsp = sp_step(nsp, !mem_nxt.ext, 1'b0);
               end
               mem_nxt.addr = nsp;
               mem_nxt.wdata = buf_nxt[7:0];
               if (user_nxt) begin
                  usp_nxt = nsp;
               end else begin
                  ssp_nxt = nsp;
               end
               st_nxt = PMS_ACC;
            end
         end
         PMS_ACC: begin
            if (i_mem_ack) begin
               nsp = cur_sp;
               if (!mem_r.we) begin
                  pop_nxt = {pop_r[7:0], i_mem_rdata};
                  nsp = sp_step(cur_sp, cur_int, 1'b1);
               end
               if (cnt_r == 2'h1) begin
                  mem_nxt.req = 1'b0;
                  pop_done_nxt = !mem_r.we;
                  st_nxt = PMS_IDLE;
               end else begin
                  buf_nxt = {8'h0, buf_r[23:8]};
                  if (mem_r.we) begin
                     nsp = sp_step(cur_sp, cur_int, 1'b0);
                  end
                  mem_nxt.addr = nsp;
                  mem_nxt.wdata = buf_r[15:8];
               end
               cnt_nxt = cnt_r - 2'h1;
               if (user_r) begin
                  usp_nxt = nsp;
               end else begin
                  ssp_nxt = nsp;
               end
            end
         end
         default: st_nxt = PMS_IDLE;
      endcase
      busy_nxt = (st_nxt != PMS_IDLE);
   end

   // Clock stage: optional halving then a 1..8 prescaler on the input clock.
   always_comb begin
      half_nxt = mode_r[`PMS_MODE_OSC_HALVE_ENABLE] ? !half_r : 1'b1;
      pcnt_nxt = pcnt_r;
      tick_nxt = 1'b0;
      if (half_r || !mode_r[`PMS_MODE_OSC_HALVE_ENABLE]) begin
         if (pcnt_r >= mode_r[`PMS_MODE_PRS_HI:`PMS_MODE_PRS_LO]) begin
            pcnt_nxt = 3'h0;
            tick_nxt = 1'b1;
         end else begin
            pcnt_nxt = pcnt_r + 3'h1;
         end
      end
   end

   // Bus request gating and bus float drive masks.
   always_comb begin
      brq_nxt = i_ext_bus_request_input && mode_r[`PMS_MODE_BRQ];
      p0f_nxt = mode_r[`PMS_MODE_BUS_FLOAT_ENABLE] && i_p0_addr_mode;
      p1f_nxt = {8{mode_r[`PMS_MODE_BUS_FLOAT_ENABLE]}} & i_p1_addr_mask;
      ctlf_nxt = mode_r[`PMS_MODE_BUS_FLOAT_ENABLE] && (i_p0_addr_mode || (|i_p1_addr_mask));
   end

   // Pointer and page state carries no reset; software must load it first.
   always_ff @(posedge i_clk) begin
      page_r <= page_nxt;
      ssp_r <= ssp_nxt;
      usp_r <= usp_nxt;
      if (wr_ok && i_pwrite && top_hit && !pslverr_nxt) begin
         page_mem[pm_addr] <= i_pwdata[7:0];
      end
   end

   // Control state with a defined reset value.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         mode_r <= `PMS_MODE_RST;
         st_r <= PMS_IDLE;
         mem_r <= '0;
         buf_r <= 24'h0;
         cnt_r <= 2'h0;
         user_r <= 1'b0;
         pop_r <= 16'h0;
         pop_done_r <= 1'b0;
         busy_r <= 1'b0;
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         half_r <= 1'b0;
         pcnt_r <= 3'h0;
         tick_r <= 1'b0;
         brq_r <= 1'b0;
         p0f_r <= 1'b0;
         p1f_r <= 8'h0;
         ctlf_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         st_r <= st_nxt;
         mem_r <= mem_nxt;
         buf_r <= buf_nxt;
         cnt_r <= cnt_nxt;
         user_r <= user_nxt;
         pop_r <= pop_nxt;
         pop_done_r <= pop_done_nxt;
         busy_r <= busy_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         half_r <= half_nxt;
         pcnt_r <= pcnt_nxt;
         tick_r <= tick_nxt;
         brq_r <= brq_nxt;
         p0f_r <= p0f_nxt;
         p1f_r <= p1f_nxt;
         ctlf_r <= ctlf_nxt;
      end
   end

   // Outputs, each straight from a flip-flop.
   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_stk_busy = busy_r;
   assign o_mem = mem_r;
   assign o_pop_data = pop_r;
   assign o_pop_done = pop_done_r;
   assign o_cpu_tick = tick_r;
   assign o_bus_grant_ok = brq_r;
   assign o_p0_float = p0f_r;
   assign o_p1_float = p1f_r;
   assign o_ctl_float = ctlf_r;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   property p_page_low_zero;
      pready_r && !pslverr_r && $past(!i_pwrite && idx == `PMS_IDX_PAGE) |-> prdata_r[1:0] == 2'h0;
   endproperty
   a_page_low_zero: assert property (p_page_low_zero)
      else $error("Page select low bits not zero.");

   property p_mode_reset;
      $fell(i_sys_rst) |-> mode_r == `PMS_MODE_RST;
   endproperty
   a_mode_reset: assert property (p_mode_reset)
      else $error("Mode control reset value wrong.");

   property p_push_predec;
      st_r == PMS_IDLE && i_stk_cmd.valid && i_stk_cmd.op == PMS_OP_PUSH && !i_stk_cmd.user
         && mode_r[7] |=> mem_r.addr[7:0] == $past(ssp_r[7:0]) - 8'h01 && ssp_r == mem_r.addr;
   endproperty
   a_push_predec: assert property (p_push_predec)
      else $error("Push did not pre-decrement.");

   property p_int_high_kept;
      st_r == PMS_ACC && i_mem_ack && !user_r && cur_int |=> ssp_r[15:8] == $past(ssp_r[15:8]);
   endproperty
   a_int_high_kept: assert property (p_int_high_kept)
      else $error("Internal stack moved high byte.");

   property p_user_high_kept;
      st_r == PMS_ACC && i_mem_ack && user_r && cur_int |=> usp_r[15:8] == $past(usp_r[15:8]);
   endproperty
   a_user_high_kept: assert property (p_user_high_kept)
      else $error("Internal user stack moved high byte.");

   // The stack target must follow the mode bit of the stack in use, and external means data space.
   property p_ext_dspace;
      mem_r.req |-> mem_r.dspace == mem_r.ext && mem_r.ext == !cur_int;
   endproperty
   a_ext_dspace: assert property (p_ext_dspace)
      else $error("External stack access not in data space.");

   property p_irq_system;
      st_r == PMS_IDLE && i_stk_cmd.valid && i_stk_cmd.op == PMS_OP_IRQ |=> !user_r && cnt_r == 2'h3;
   endproperty
   a_irq_system: assert property (p_irq_system)
      else $error("Interrupt entry not three system pushes.");

   property p_brq_gate;
      o_bus_grant_ok |-> $past(mode_r[1] && i_ext_bus_request_input);
   endproperty
   a_brq_gate: assert property (p_brq_gate)
      else $error("Bus request passed while disabled.");

   property p_brq_pass;
      mode_r[`PMS_MODE_BRQ] && i_ext_bus_request_input |=> o_bus_grant_ok;
   endproperty
   a_brq_pass: assert property (p_brq_pass)
      else $error("Enabled bus request not passed.");

   property p_float_io;
      $past(!i_p1_addr_mask[7]) |-> !o_p1_float[7];
   endproperty
   a_float_io: assert property (p_float_io)
      else $error("General I/O line floated.");

   property p_float_off;
      !mode_r[`PMS_MODE_BUS_FLOAT_ENABLE] |=> !o_p0_float && !o_ctl_float && o_p1_float == 8'h00;
   endproperty
   a_float_off: assert property (p_float_off)
      else $error("Bus floated while float bit clear.");

   property p_tick_halved;
      mode_r[`PMS_MODE_OSC_HALVE_ENABLE] && $past(mode_r[`PMS_MODE_OSC_HALVE_ENABLE]) && o_cpu_tick |=> !o_cpu_tick;
   endproperty
   a_tick_halved: assert property (p_tick_halved)
      else $error("CPU tick too fast with halving on.");

   property p_pop_inc;
      st_r == PMS_ACC && i_mem_ack && !mem_r.we && !user_r |=> ssp_r[7:0] == $past(mem_r.addr[7:0]) + 8'h01;
   endproperty
   a_pop_inc: assert property (p_pop_inc)
      else $error("Pop did not post-increment.");

   property p_pop_no_write;
      mem_r.req && !$past(mem_r.we) && !$rose(mem_r.req) && $stable(cnt_r) |-> !mem_r.we;
   endproperty
   a_pop_no_write: assert property (p_pop_no_write)
      else $error("Pop sequence wrote the stack.");

endmodule // pms_regs

//--- tb/pms_regs_bench.sv
// Self-checking bench for the page, mode and stack pointer register block.
// Assumes the package and the constant map header are on the include path.
`timescale 1ns/1ps
`include "pms_map.svh"
module pms_regs_bench
   import pms_pkg::*;
;
   logic i_clk, i_sys_rst, i_psel, i_penable, i_pwrite, i_mem_ack, i_ext_bus_request_input, i_p0_addr_mode;
   logic [31:0] i_paddr, i_pwdata, o_prdata, rdv;
   logic o_pready, o_pslverr, o_stk_busy, o_pop_done, o_cpu_tick, o_bus_grant_ok, o_p0_float, o_ctl_float, erv;
   logic [7:0] i_mem_rdata, i_p1_addr_mask, o_p1_float;
   logic [15:0] o_pop_data;
   pms_cmd_t i_stk_cmd;
   pms_acc_t o_mem;
   int mismatches = 0;
   int checks_done = 0;

   pms_regs pms_regs_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .i_stk_cmd(i_stk_cmd), .o_stk_busy(o_stk_busy), .o_mem(o_mem),
      .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_pop_data(o_pop_data), .o_pop_done(o_pop_done),
      .o_cpu_tick(o_cpu_tick), .i_ext_bus_request_input(i_ext_bus_request_input),
      .o_bus_grant_ok(o_bus_grant_ok), .i_p0_addr_mode(i_p0_addr_mode), .i_p1_addr_mask(i_p1_addr_mask),
      .o_p0_float(o_p0_float), .o_p1_float(o_p1_float), .o_ctl_float(o_ctl_float));

   // Free-running 200 MHz clock.
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // Compares one value and counts it; case inequality lets no unknown pass.
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the verdict and stops the run.
   task close_out();
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One APB transfer; upper write bits are set to show they are ignored.
   task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= {22'h0, idx, 2'b00};
      i_pwdata <= {24'hFFFFFF, wd};
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 200);
      rd = o_prdata;
      er = o_pslverr;
      check(32'(o_pready), 32'h1);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task wr(input logic [7:0] idx, input logic [7:0] wd);
      apb(1'b1, idx, wd, rdv, erv);
   endtask

   task rdchk(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00, rdv, erv);
      check(rdv, {24'h0, exp});
      check(32'(erv), 32'h0);
   endtask

   // Issues one stack command once the sequencer is idle; held for the taking edge only.
   task stk(input pms_op_t op, input logic u, input logic [15:0] d, input logic [15:0] pc, input logic [7:0] f);
      @(posedge i_clk);
      while (o_stk_busy === 1'b1) @(posedge i_clk);
      i_stk_cmd <= '{1'b1, op, u, d, pc, f};
      @(posedge i_clk);
      i_stk_cmd.valid <= 1'b0;
   endtask

   // Answers one byte access after checking it; released read data is inverted, not held.
   task mexp(input logic we, input logic ext, input logic [15:0] a, input logic [7:0] wd, input logic [7:0] rd);
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_mem.req !== 1'b1 && n < 100);
      check(32'(o_mem.we), 32'(we));
      check(32'(o_mem.ext), 32'(ext));
      if (ext) begin
         check(32'(o_mem.dspace), 32'h1);
         check(32'(o_mem.addr), 32'(a));
      end else begin
         check(32'(o_mem.addr[7:0]), 32'(a[7:0]));
      end
      if (we) begin
         check(32'(o_mem.wdata), 32'(wd));
      end
      i_mem_ack <= 1'b1;
      i_mem_rdata <= rd;
      @(posedge i_clk);
      i_mem_ack <= 1'b0;
      i_mem_rdata <= ~rd;
   endtask

   task popchk(input logic [15:0] exp);
      @(posedge i_clk);
      check(32'(o_pop_done), 32'h1);
      check(32'(o_pop_data), 32'(exp));
   endtask

   // Measures the spacing of two CPU ticks after the divider has settled.
   task tick(input int exp);
      int n;
      repeat (20) @(posedge i_clk);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge i_clk);
            n++;
         end while (o_cpu_tick !== 1'b1 && n < 60);
      end
      check(32'(n), 32'(exp));
   endtask

   // Hang guard, far beyond the few hundred cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      close_out();
   end

   // Main sequence.
   initial begin
      {i_psel, i_penable, i_pwrite, i_mem_ack, i_ext_bus_request_input, i_p0_addr_mode} = '0;
      i_paddr = '0;
      i_pwdata = '0;
      i_mem_rdata = '0;
      i_p1_addr_mask = '0;
      i_stk_cmd = '0;
      i_sys_rst = 1'b1;
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rdchk(`PMS_IDX_MODE, 8'hE0);
      wr(`PMS_IDX_PAGE, 8'hFF);
      rdchk(`PMS_IDX_PAGE, 8'hFC);
      wr(`PMS_IDX_PAGE, 8'h14);
      wr(8'hF2, 8'h2C);
      wr(`PMS_IDX_PAGE, 8'h18);
      wr(8'hF2, 8'h11);
      wr(`PMS_IDX_PAGE, 8'hFC);
      wr(8'hFF, 8'h5A);
      wr(`PMS_IDX_PAGE, 8'h18);
      rdchk(8'hF2, 8'h11);
      wr(`PMS_IDX_PAGE, 8'h14);
      rdchk(8'hF2, 8'h2C);
      wr(`PMS_IDX_PAGE, 8'hFC);
      rdchk(8'hFF, 8'h5A);
      apb(1'b0, 8'h10, 8'h00, rdv, erv);
      check(32'(erv), 32'h1);
      check(rdv, 32'h0);
      // Bus request passes only with the enable bit; float follows mode bit 0 and the masks.
      i_ext_bus_request_input <= 1'b1;
      i_p0_addr_mode <= 1'b1;
      i_p1_addr_mask <= 8'h1F;
      wr(`PMS_IDX_MODE, 8'hE3);
      repeat (3) @(posedge i_clk);
      check(32'(o_bus_grant_ok), 32'h1);
      check(32'({o_p1_float, o_p0_float, o_ctl_float}), 32'h7F);
      wr(`PMS_IDX_MODE, 8'hE0);
      repeat (3) @(posedge i_clk);
      check(32'(o_bus_grant_ok), 32'h0);
      check(32'({o_p1_float, o_p0_float, o_ctl_float}), 32'h0);
      // Clock divider: prescaler factor, then halving on top.
      wr(`PMS_IDX_MODE, 8'h08);
      tick(3);
      wr(`PMS_IDX_MODE, 8'h28);
      tick(6);
      wr(`PMS_IDX_MODE, 8'hFC);
      tick(16);
      // Internal stacks: only the low pointer byte moves.
      wr(`PMS_IDX_MODE, 8'hC0);
      wr(`PMS_IDX_SSPH, 8'h12);
      wr(`PMS_IDX_SSPL, 8'hDC);
      stk(PMS_OP_PUSH, 1'b0, 16'h00A5, 16'h0, 8'h0);
      mexp(1'b1, 1'b0, 16'h00DB, 8'hA5, 8'h00);
      rdchk(`PMS_IDX_SSPL, 8'hDB);
      rdchk(`PMS_IDX_SSPH, 8'h12);
      stk(PMS_OP_POP, 1'b0, 16'h0, 16'h0, 8'h0);
      mexp(1'b0, 1'b0, 16'h00DB, 8'h00, 8'h77);
      rdchk(`PMS_IDX_SSPL, 8'hDC);
      wr(`PMS_IDX_USPH, 8'h34);
      wr(`PMS_IDX_USPL, 8'hDF);
      stk(PMS_OP_PUSHW, 1'b1, 16'h1234, 16'h0, 8'h0);
      mexp(1'b1, 1'b0, 16'h00DE, 8'h34, 8'h00);
      mexp(1'b1, 1'b0, 16'h00DD, 8'h12, 8'h00);
      rdchk(`PMS_IDX_USPL, 8'hDD);
      rdchk(`PMS_IDX_USPH, 8'h34);
      rdchk(`PMS_IDX_SSPL, 8'hDC);
      stk(PMS_OP_POPW, 1'b1, 16'h0, 16'h0, 8'h0);
      mexp(1'b0, 1'b0, 16'h00DD, 8'h00, 8'h56);
      mexp(1'b0, 1'b0, 16'h00DE, 8'h00, 8'h78);
      popchk(16'h5678);
      rdchk(`PMS_IDX_USPL, 8'hDF);
      // External system stack: full address, data space, call and interrupt context.
      wr(`PMS_IDX_MODE, 8'h00);
      wr(`PMS_IDX_SSPL, 8'h34);
      stk(PMS_OP_CALL, 1'b0, 16'h0, 16'hABCD, 8'h0);
      mexp(1'b1, 1'b1, 16'h1233, 8'hCD, 8'h00);
      mexp(1'b1, 1'b1, 16'h1232, 8'hAB, 8'h00);
      stk(PMS_OP_IRQ, 1'b0, 16'h0, 16'h1357, 8'h9A);
      mexp(1'b1, 1'b1, 16'h1231, 8'h57, 8'h00);
      mexp(1'b1, 1'b1, 16'h1230, 8'h13, 8'h00);
      mexp(1'b1, 1'b1, 16'h122F, 8'h9A, 8'h00);
      rdchk(`PMS_IDX_SSPH, 8'h12);
      rdchk(`PMS_IDX_SSPL, 8'h2F);
      close_out();
   end
endmodule // pms_regs_bench
